// [common/csl_pkg.sv]
// Shared constants for the charger supervisor logic
package csl_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int unsigned CLK_HZ         = 10_000_000;
	localparam int unsigned INT_PULSE_US   = 256;
	localparam int unsigned INT_PULSE_CYC  = INT_PULSE_US * (CLK_HZ / 1_000_000);
	localparam int unsigned BLANK_US       = 50;
	localparam int unsigned BLANK_CYC      = BLANK_US * (CLK_HZ / 1_000_000);
	localparam int unsigned BLINK_HZ       = 1;
	localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
	localparam int unsigned HICCUP_MS      = 600;
	localparam int unsigned HICCUP_CYC     = HICCUP_MS * (CLK_HZ / 1000);
	localparam int unsigned SHIP_DELAY_S   = 10;
	localparam int unsigned SHIP_DELAY_CYC = SHIP_DELAY_S * CLK_HZ;
	localparam int unsigned SEC_CYC        = CLK_HZ;

	////////////////////////////////////////////////////////////////////////
	// Timer limits in seconds
	localparam int unsigned SEC_W          = 18;
	localparam logic [17:0] PRE_LIMIT_S    = 18'h00e10;
	localparam logic [17:0] FAST_LIMIT0_S  = 18'h02a30;
	localparam logic [17:0] FAST_LIMIT1_S  = 18'h04650;
	localparam logic [17:0] FAST_LIMIT2_S  = 18'h07080;
	localparam logic [17:0] FAST_LIMIT3_S  = 18'h0a8c0;
	localparam logic [17:0] WDOG_LIMIT_S   = 18'h00028;

	////////////////////////////////////////////////////////////////////////
	// Field codes and reset values
	localparam logic [1:0] CHG_FIELD_OFF    = 2'h0;
	localparam logic [1:0] CHG_FIELD_CHARGE = 2'h1;
	localparam logic [5:0] JEITA_CFG_RST    = 6'h00;
	localparam int unsigned EV_W            = 7;

	typedef enum logic [1:0] {
		CSL_DS_ON    = 2'b00,
		CSL_DS_BLANK = 2'b01,
		CSL_DS_OFF   = 2'b10
	} csl_dschg_t;

	typedef enum logic [1:0] {
		CSL_SH_ON    = 2'b00,
		CSL_SH_DELAY = 2'b01,
		CSL_SH_OFF   = 2'b10
	} csl_ship_t;

	// Fast-charge limit by two-bit select
	function automatic logic [17:0] csl_fast_limit(input logic [1:0] sel);
		case (sel)
			2'h0:    csl_fast_limit = FAST_LIMIT0_S;
			2'h1:    csl_fast_limit = FAST_LIMIT1_S;
			2'h2:    csl_fast_limit = FAST_LIMIT2_S;
			default: csl_fast_limit = FAST_LIMIT3_S;
		endcase
	endfunction

	// Rising-edge mask of a vector
	function automatic logic [6:0] csl_rise(input logic [6:0] cur,
	                                        input logic [6:0] prev);
		csl_rise = cur & ~prev;
	endfunction

endpackage

// [common/csl_tmr_if.sv]
// Link between the supervisor and its safety timer
`timescale 1ns/10ps
interface csl_tmr_if;
	logic       sec_tick;
	logic       restart;
	logic       run;
	logic       half_rate;
	logic       precharge;
	logic       clear_fault;
	logic [1:0] time_sel;
	logic       fault;

	modport ctrl  (output sec_tick, restart, run, half_rate, precharge,
	               clear_fault, time_sel, input fault);
	modport timer (input sec_tick, restart, run, half_rate, precharge,
	               clear_fault, time_sel, output fault);
endinterface

// [design/csl_safety_timer.sv]
// Pre-charge and fast-charge safety timer
`timescale 1ns/10ps
module csl_safety_timer (
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	csl_tmr_if.timer  tmr
);
	import csl_pkg::*;

	logic [SEC_W-1:0] cnt_r;
	logic [SEC_W-1:0] cnt_nxt;
	logic             half_r;
	logic             fault_r;
	wire  [SEC_W-1:0] limit;
	wire              advance;
	wire              hit;

	////////////////////////////////////////////////////////////////////////
	// Limit and advance
	assign limit   = tmr.precharge ? PRE_LIMIT_S
	                               : csl_fast_limit(tmr.time_sel);
	assign advance = tmr.run && tmr.sec_tick
	                 && (!tmr.half_rate || half_r);
	assign cnt_nxt = cnt_r + {{(SEC_W-1){1'b0}}, 1'b1};
	assign hit     = advance && (cnt_nxt >= limit);
	assign tmr.fault = fault_r;

	////////////////////////////////////////////////////////////////////////
	// Counter
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_r  <= '0;
			half_r <= 1'b0;
		end else if (tmr.restart) begin
			cnt_r  <= '0;
			half_r <= 1'b0;
		end else begin
			if (advance && !hit)
				cnt_r <= cnt_nxt;
			if (tmr.run && tmr.sec_tick && tmr.half_rate)
				half_r <= ~half_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Expiry flag, set wins over clear
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			fault_r <= 1'b0;
		else if (hit)
			fault_r <= 1'b1;
		else if (tmr.clear_fault)
			fault_r <= 1'b0;
	end
endmodule

// [design/charger_supervisor_logic.sv]
// Supervisory control logic of a single-cell charger
`timescale 1ns/10ps
module charger_supervisor_logic #(
	parameter int unsigned SEC_CYCLES    = csl_pkg::SEC_CYC,
	parameter int unsigned BLINK_CYCLES  = csl_pkg::BLINK_HALF_CYC,
	parameter int unsigned HICCUP_CYCLES = csl_pkg::HICCUP_CYC,
	parameter int unsigned SHIP_CYCLES   = csl_pkg::SHIP_DELAY_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       temp_scheme_select_i,
	input  wire logic       board_overtemp_select_i,
	input  wire logic       boost_temp_check_enable_i,
	input  wire logic [5:0] jeita_thresh_cfg_i,
	input  wire logic       float_step_sel_i,
	input  wire logic       cool_current_sel_i,
	input  wire logic       ntc_below_hot_i,
	input  wire logic       ntc_below_warm_i,
	input  wire logic       ntc_above_cool_i,
	input  wire logic       ntc_above_cold_i,
	input  wire logic       ntc_above_float_i,
	input  wire logic       stat_enable_i,
	input  wire logic [1:0] charge_operation_field_i,
	input  wire logic       charge_enable_pin_n_i,
	input  wire logic [1:0] fast_charge_time_select_i,
	input  wire logic       timer_enable_i,
	input  wire logic       slow_timer_enable_i,
	input  wire logic       reference_enable_i,
	input  wire logic       watchdog_enable_i,
	input  wire logic       watchdog_kick_i,
	input  wire logic       battery_switch_off_request_i,
	input  wire logic       ship_delay_sel_i,
	input  wire logic       input_good_i,
	input  wire logic       input_present_i,
	input  wire logic       input_ovp_i,
	input  wire logic       port_det_done_i,
	input  wire logic       charge_done_i,
	input  wire logic       recharge_i,
	input  wire logic       batt_below_precharge_i,
	input  wire logic       cc_phase_i,
	input  wire logic       batt_ovp_i,
	input  wire logic       sys_ovp_i,
	input  wire logic       input_limit_i,
	input  wire logic       input_vreg_i,
	input  wire logic       die_reg_i,
	input  wire logic       die_over_shutdown_i,
	input  wire logic       die_below_recover_i,
	input  wire logic       boost_request_i,
	input  wire logic       boost_fault_i,
	input  wire logic       discharge_mode_i,
	input  wire logic       discharge_over_limit_i,
	input  wire logic       discharge_fast_limit_i,
	output logic            charge_enable_o,
	output logic            float_reduce_o,
	output logic            current_reduce_o,
	output logic [5:0]      jeita_thresh_o,
	output logic            converter_enable_o,
	output logic            battery_switch_on_o,
	output logic            discharge_switch_on_o,
	output logic            boost_enable_o,
	output logic            thermistor_fault_o,
	output logic            thermistor_open_flag_o,
	output logic            timer_fault_o,
	output logic            watchdog_fault_o,
	output logic            watchdog_defaults_o,
	output logic            die_temp_regulating_flag_o,
	output logic            die_shutdown_flag_o,
	output logic            stat_o,
	output logic            stat_oe_o,
	output logic            int_n_o
);
	import csl_pkg::*;

	csl_tmr_if tmr ();

	logic [23:0]      sec_cnt_r;
	logic             sec_tick_r;
	logic [6:0]       ev_prev_r;
	logic [11:0]      int_cnt_r;
	logic [22:0]      blink_cnt_r;
	logic             blink_r;
	logic             shut_r;
	logic [1:0]       field_prev_r;
	logic             ten_prev_r;
	logic             ref_prev_r;
	logic             inp_prev_r;
	logic             cc_prev_r;
	logic             pin_high_seen_r;
	logic             pin_prev_r;
	logic             wen_prev_r;
	logic [SEC_W-1:0] wd_cnt_r;
	logic             wd_fault_r;
	logic             wd_def_r;
	csl_dschg_t       ds_state_r;
	csl_dschg_t       ds_state_nxt;
	logic [22:0]      ds_cnt_r;
	csl_ship_t        sh_state_r;
	csl_ship_t        sh_state_nxt;
	logic [26:0]      sh_cnt_r;
	logic             req_prev_r;

	////////////////////////////////////////////////////////////////////////
	// Temperature qualification
	wire temp_out   = ntc_below_hot_i || ntc_above_cold_i;
	wire batt_mode  = !board_overtemp_select_i;
	wire ntc_fault  = batt_mode && temp_out;
	wire board_hot  = board_overtemp_select_i && ntc_below_hot_i;
	wire four_zone  = batt_mode && temp_scheme_select_i;
	wire warm_zone  = four_zone && !ntc_below_hot_i && ntc_below_warm_i;
	wire cool_zone  = four_zone && ntc_above_cool_i && !ntc_above_cold_i;
	wire open_ntc   = ntc_above_float_i;

	////////////////////////////////////////////////////////////////////////
	// Charge gating
	wire chg_allowed = (charge_operation_field_i == CHG_FIELD_CHARGE)
	                   && !charge_enable_pin_n_i;
	wire suspend     = ntc_fault || open_ntc || batt_ovp_i || sys_ovp_i
	                   || tmr.fault;
	wire power_off   = board_hot || shut_r;
	wire charging    = chg_allowed && !suspend && !power_off && !charge_done_i
	                   && !input_ovp_i && !discharge_mode_i;
	wire boost_temp_bad = boost_temp_check_enable_i && batt_mode && temp_out;

	////////////////////////////////////////////////////////////////////////
	// Safety timer control
	wire field_on  = (field_prev_r == CHG_FIELD_OFF)
	                 && (charge_operation_field_i == CHG_FIELD_CHARGE);
	wire pin_cycle = pin_high_seen_r && pin_prev_r && !charge_enable_pin_n_i;
	wire ref_fall  = ref_prev_r && !reference_enable_i;
	wire inp_rise  = input_present_i && !inp_prev_r;
	wire cc_rise   = cc_phase_i && !cc_prev_r;
	wire ten_rise  = timer_enable_i && !ten_prev_r;
	wire tmr_pause = batt_ovp_i || ntc_fault || open_ntc;

	assign tmr.sec_tick    = sec_tick_r;
	assign tmr.restart     = inp_rise || recharge_i || pin_cycle || field_on
	                         || ten_rise || ref_fall || cc_rise;
	assign tmr.clear_fault = ref_fall || inp_rise;
	assign tmr.run         = chg_allowed && timer_enable_i && !charge_done_i
	                         && !tmr_pause && !boost_request_i;
	assign tmr.half_rate   = slow_timer_enable_i
	                         && (input_limit_i || input_vreg_i || die_reg_i);
	assign tmr.precharge   = batt_below_precharge_i;
	assign tmr.time_sel    = fast_charge_time_select_i;

	csl_safety_timer u_timer (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.tmr       (tmr)
	);

	////////////////////////////////////////////////////////////////////////
	// Interrupt events
	wire [6:0] ev_now = {
		input_good_i,
		port_det_done_i,
		!input_present_i,
		charge_done_i,
		open_ntc,
		input_limit_i || input_vreg_i,
		wd_fault_r || boost_fault_i || shut_r || tmr.fault || batt_ovp_i
		|| ntc_fault
	};
	wire int_fire = |csl_rise(ev_now, ev_prev_r);
	wire wd_kick  = watchdog_kick_i || (watchdog_enable_i && !wen_prev_r);
	wire wd_hit   = watchdog_enable_i && sec_tick_r && !wd_fault_r
	                && (wd_cnt_r >= WDOG_LIMIT_S - 18'h00001);

	////////////////////////////////////////////////////////////////////////
	// Second tick, edge history, die shutdown
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sec_cnt_r       <= '0;
			sec_tick_r      <= 1'b0;
			ev_prev_r       <= '0;
			field_prev_r    <= CHG_FIELD_OFF;
			ten_prev_r      <= 1'b0;
			ref_prev_r      <= 1'b0;
			inp_prev_r      <= 1'b0;
			cc_prev_r       <= 1'b0;
			pin_prev_r      <= 1'b1;
			pin_high_seen_r <= 1'b0;
			wen_prev_r      <= 1'b0;
			req_prev_r      <= 1'b0;
		end else begin
			sec_tick_r   <= (sec_cnt_r == 24'(SEC_CYCLES - 1));
			sec_cnt_r    <= (sec_cnt_r == 24'(SEC_CYCLES - 1)) ? '0
			                : sec_cnt_r + 24'h000001;
			ev_prev_r    <= ev_now;
			field_prev_r <= charge_operation_field_i;
			ten_prev_r   <= timer_enable_i;
			ref_prev_r   <= reference_enable_i;
			inp_prev_r   <= input_present_i;
			cc_prev_r    <= cc_phase_i;
			pin_prev_r   <= charge_enable_pin_n_i;
			wen_prev_r   <= watchdog_enable_i;
			req_prev_r   <= battery_switch_off_request_i;
			if (!pin_prev_r && charge_enable_pin_n_i)
				pin_high_seen_r <= 1'b1;
			else if (pin_cycle)
				pin_high_seen_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			shut_r <= 1'b0;
		else if (die_over_shutdown_i)
			shut_r <= 1'b1;
		else if (die_below_recover_i)
			shut_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt pulse, retriggered by a new event
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			int_cnt_r <= '0;
		else if (int_fire)
			int_cnt_r <= 12'(INT_PULSE_CYC);
		else if (int_cnt_r != 12'h000)
			int_cnt_r <= int_cnt_r - 12'h001;
	end

	////////////////////////////////////////////////////////////////////////
	// Indicator blink
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			blink_cnt_r <= '0;
			blink_r     <= 1'b0;
		end else if (!(chg_allowed && suspend)) begin
			blink_cnt_r <= '0;
			blink_r     <= 1'b0;
		end else if (blink_cnt_r == 23'(BLINK_CYCLES - 1)) begin
			blink_cnt_r <= '0;
			blink_r     <= ~blink_r;
		end else
			blink_cnt_r <= blink_cnt_r + 23'h000001;
	end

	////////////////////////////////////////////////////////////////////////
	// Watchdog, expiry wins over a kick in the same cycle
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wd_cnt_r   <= '0;
			wd_fault_r <= 1'b0;
			wd_def_r   <= 1'b0;
		end else begin
			wd_def_r <= wd_hit;
			if (wd_hit) begin
				wd_fault_r <= 1'b1;
				wd_cnt_r   <= '0;
			end else if (wd_kick) begin
				wd_fault_r <= 1'b0;
				wd_cnt_r   <= '0;
			end else if (watchdog_enable_i && sec_tick_r && !wd_fault_r)
				wd_cnt_r <= wd_cnt_r + 18'h00001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Discharge hiccup
	always_comb begin
		ds_state_nxt = ds_state_r;
		case (ds_state_r)
			CSL_DS_ON: begin
				if (discharge_mode_i && discharge_fast_limit_i)
					ds_state_nxt = CSL_DS_OFF;
				else if (discharge_mode_i && discharge_over_limit_i)
					ds_state_nxt = CSL_DS_BLANK;
			end
			CSL_DS_BLANK: begin
				if (discharge_fast_limit_i)
					ds_state_nxt = CSL_DS_OFF;
				else if (!discharge_over_limit_i || !discharge_mode_i)
					ds_state_nxt = CSL_DS_ON;
				else if (ds_cnt_r == 23'(BLANK_CYC - 1))
					ds_state_nxt = CSL_DS_OFF;
			end
			CSL_DS_OFF: begin
				if (ds_cnt_r == 23'(HICCUP_CYCLES - 1))
					ds_state_nxt = CSL_DS_ON;
			end
			default: ds_state_nxt = CSL_DS_ON;
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ds_state_r <= CSL_DS_ON;
			ds_cnt_r   <= '0;
		end else begin
			ds_state_r <= ds_state_nxt;
			ds_cnt_r   <= (ds_state_nxt != ds_state_r) ? '0
			              : ds_cnt_r + 23'h000001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shipping disconnect
	always_comb begin
		sh_state_nxt = sh_state_r;
		case (sh_state_r)
			CSL_SH_ON: begin
				if (battery_switch_off_request_i && !req_prev_r)
					sh_state_nxt = ship_delay_sel_i ? CSL_SH_DELAY
					                                : CSL_SH_OFF;
			end
			CSL_SH_DELAY: begin
				if (!battery_switch_off_request_i)
					sh_state_nxt = CSL_SH_ON;
				else if (sh_cnt_r == 27'(SHIP_CYCLES - 1))
					sh_state_nxt = CSL_SH_OFF;
			end
			CSL_SH_OFF: begin
				if (!battery_switch_off_request_i)
					sh_state_nxt = CSL_SH_ON;
			end
			default: sh_state_nxt = CSL_SH_ON;
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sh_state_r <= CSL_SH_ON;
			sh_cnt_r   <= '0;
		end else begin
			sh_state_r <= sh_state_nxt;
			sh_cnt_r   <= (sh_state_nxt != sh_state_r) ? '0
			              : sh_cnt_r + 27'h0000001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign charge_enable_o       = charging;
	assign float_reduce_o        = warm_zone && float_step_sel_i;
	assign current_reduce_o      = cool_zone && cool_current_sel_i;
	assign jeita_thresh_o        = jeita_thresh_cfg_i;
	assign converter_enable_o    = !power_off;
	assign battery_switch_on_o   = !power_off && (sh_state_r != CSL_SH_OFF)
	                               && (ds_state_r != CSL_DS_OFF);
	assign discharge_switch_on_o = (ds_state_r != CSL_DS_OFF);
	assign boost_enable_o        = boost_request_i && !boost_temp_bad
	                               && !power_off;
	assign thermistor_fault_o    = ntc_fault;
	assign thermistor_open_flag_o = open_ntc;
	assign timer_fault_o         = tmr.fault;
	assign watchdog_fault_o      = wd_fault_r;
	assign watchdog_defaults_o   = wd_def_r;
	assign die_temp_regulating_flag_o = die_reg_i;
	assign die_shutdown_flag_o   = shut_r;
	assign stat_o                = 1'b0;
	assign stat_oe_o             = stat_enable_i && (charging
	                               || (chg_allowed && suspend && !input_ovp_i
	                                   && !discharge_mode_i && blink_r));
	assign int_n_o               = (int_cnt_r == 12'h000);
endmodule

// [tb/csl_properties.sv]
// Port checker for the charger supervisor
`timescale 1ns/10ps
module csl_properties (
	input wire logic       clk_i, reset_n_i, int_n_o, ntc_above_float_i,
	input wire logic       thermistor_open_flag_o, charge_enable_pin_n_i,
	input wire logic       charge_enable_o, board_overtemp_select_i,
	input wire logic       ntc_below_hot_i, converter_enable_o,
	input wire logic       battery_switch_on_o, die_reg_i, stat_oe_o,
	input wire logic       die_temp_regulating_flag_o, ship_delay_sel_i,
	input wire logic       battery_switch_off_request_i, discharge_mode_i,
	input wire logic       discharge_fast_limit_i, discharge_switch_on_o,
	input wire logic       stat_enable_i, timer_fault_o,
	input wire logic [1:0] charge_operation_field_i,
	input wire logic [5:0] jeita_thresh_cfg_i, jeita_thresh_o
);
	import csl_pkg::*;
	logic [11:0] low_r;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	////////////////////////////////////////////////////////////////////////
	// Length of the present interrupt low phase
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			low_r <= 12'h000;
		else
			low_r <= int_n_o ? 12'h000 : low_r + 12'h001;
	end
	a_int_width: assert property (
		$rose(int_n_o) |-> low_r >= 12'ha00) else $error("pulse short");
	a_float_int: assert property (
		$rose(ntc_above_float_i) |=> ##1 !int_n_o) else $error("no int");
	a_open_flag: assert property (
		thermistor_open_flag_o == ntc_above_float_i) else $error("flag");
	a_thresh_pass: assert property (
		jeita_thresh_o == jeita_thresh_cfg_i) else $error("thresh");
	a_charge_gate: assert property (
		charge_enable_o |-> charge_operation_field_i == 2'h1 &&
		!charge_enable_pin_n_i) else $error("charge gate");
	a_board_hot: assert property (
		board_overtemp_select_i && ntc_below_hot_i |->
		!converter_enable_o && !battery_switch_on_o) else $error("board");
	a_die_flag: assert property (
		die_temp_regulating_flag_o == die_reg_i) else $error("die flag");
	a_ship_now: assert property (
		$rose(battery_switch_off_request_i) && !ship_delay_sel_i |=>
		!battery_switch_on_o) else $error("ship");
	a_fast_off: assert property (
		$rose(discharge_fast_limit_i) && discharge_mode_i |=>
		!discharge_switch_on_o) else $error("fast off");
	a_stat_low: assert property (
		charge_enable_o && stat_enable_i |-> stat_oe_o) else $error("stat");
	cover property ($fell(int_n_o));
	cover property ($rose(timer_fault_o));
	cover property ($fell(discharge_switch_on_o));
endmodule
bind charger_supervisor_logic csl_properties u_props (.*);

// [tb/csl_host_model.sv]
// Host side: counts interrupt pulses, kicks the watchdog
`timescale 1ns/10ps
module csl_host_model (
	input  wire logic clk_i,
	input  wire logic int_n_o,
	output logic      watchdog_kick_i
);
	int   int_count = 0;
	logic last_r = 1'h1;
	initial watchdog_kick_i = 1'h0;
	always @(posedge clk_i) begin
		int_count <= int_count + 32'(last_r & ~int_n_o);
		last_r <= int_n_o;
	end
	// One-cycle kick before expiry
	task kick;
		@(posedge clk_i);
		watchdog_kick_i <= 1'h1;
		@(posedge clk_i);
		watchdog_kick_i <= 1'h0;
	endtask
endmodule

// [tb/tb.sv]
// Testbench for the charger supervisor
`timescale 1ns/10ps
module tb;
	import csl_pkg::*;
	logic clk_i = 1'h0;
	bit reset_n_i, temp_scheme_select_i, board_overtemp_select_i;
	bit boost_temp_check_enable_i, float_step_sel_i, cool_current_sel_i;
	bit ntc_below_hot_i, ntc_below_warm_i, ntc_above_cool_i, ntc_above_cold_i;
	bit ntc_above_float_i, charge_enable_pin_n_i, timer_enable_i;
	bit slow_timer_enable_i, watchdog_enable_i, battery_switch_off_request_i;
	bit ship_delay_sel_i, input_good_i, input_ovp_i, port_det_done_i;
	bit charge_done_i, recharge_i, batt_below_precharge_i, cc_phase_i;
	bit batt_ovp_i, sys_ovp_i, input_limit_i, input_vreg_i, die_reg_i;
	bit die_over_shutdown_i, die_below_recover_i, boost_request_i;
	bit boost_fault_i, discharge_mode_i, discharge_over_limit_i;
	bit discharge_fast_limit_i, stat_enable_i = 1'h1, input_present_i = 1'h1;
	bit reference_enable_i = 1'h1;
	bit [5:0] jeita_thresh_cfg_i;
	bit [1:0] charge_operation_field_i, fast_charge_time_select_i;
	logic charge_enable_o, float_reduce_o, current_reduce_o, stat_o, stat_oe_o;
	logic converter_enable_o, battery_switch_on_o, discharge_switch_on_o;
	logic boost_enable_o, thermistor_fault_o, thermistor_open_flag_o;
	logic timer_fault_o, watchdog_fault_o, watchdog_defaults_o, int_n_o;
	logic die_temp_regulating_flag_o, die_shutdown_flag_o;
	logic [5:0] jeita_thresh_o;
	wire watchdog_kick_i;
	int num_errors = 0, compares = 0, cyc = 0, n, p, c0;
	// In: field pin_n hot board float scheme warm cool fsel csel
	// Out: charge stat_oe conv open fred cred
	logic [16:0] rows [9] = '{17'h08038, 17'h00008, 17'h0c008, 17'h0a008,
		17'h0b000, 17'h0880c, 17'h086ba, 17'h08579, 17'h08638};
	charger_supervisor_logic #(.SEC_CYCLES(10), .BLINK_CYCLES(4),
		.HICCUP_CYCLES(20), .SHIP_CYCLES(30)) dut (.*);
	csl_host_model host (.clk_i(clk_i), .int_n_o(int_n_o),
		.watchdog_kick_i(watchdog_kick_i));
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////////////
	task ck(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic await(ref logic s, input logic v, output int k);
		k = 0;
		while (s !== v && k < 99999) begin
			@(negedge clk_i);
			k++;
		end
	endtask
	task nx(input int k);
		repeat (k) @(negedge clk_i);
	endtask
	task finish_test;
		$display("compares=%0d num_errors=%0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 85000) begin
			num_errors++;
			finish_test;
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1'h1;
		for (int i = 0; i < 9; i++) begin
			@(posedge clk_i);
			{charge_operation_field_i, charge_enable_pin_n_i, ntc_below_hot_i,
				board_overtemp_select_i, ntc_above_float_i, temp_scheme_select_i,
				ntc_below_warm_i, ntc_above_cool_i, float_step_sel_i,
				cool_current_sel_i} <= rows[i][16:6];
			jeita_thresh_cfg_i <= 6'h2a ^ 6'(i);
			nx(2);
			ck(16'({charge_enable_o, stat_oe_o, converter_enable_o,
				thermistor_open_flag_o, float_reduce_o, current_reduce_o}),
				16'(rows[i][5:0]));
		end
		@(posedge clk_i);
		ntc_below_hot_i <= 1'h1;
		nx(2);
		p = stat_oe_o;
		n = 0;
		repeat (16) begin
			@(negedge clk_i);
			n += (stat_oe_o !== p);
			p = stat_oe_o;
		end
		ck(n, 4);
		ck({thermistor_fault_o, stat_o}, 2'h2);
		{boost_request_i, boost_temp_check_enable_i} <= 2'h3;
		nx(1);
		ck(boost_enable_o, 1'h0);
		ntc_below_hot_i <= 1'h0;
		nx(1);
		ck(stat_oe_o, 1'h1);
		ck({boost_enable_o, thermistor_fault_o}, 2'h2);
		{boost_request_i, boost_temp_check_enable_i} <= 2'h0;
		c0 = host.int_count;
		for (int i = 0; i < 8; i++) begin
			await(int_n_o, 1'h1, n);
			@(posedge clk_i);
			{input_good_i, port_det_done_i, charge_done_i, ntc_above_float_i,
				input_limit_i, input_vreg_i, boost_fault_i,
				batt_ovp_i} <= 8'h01 << i;
			await(int_n_o, 1'h0, n);
			ck(n inside {[1:2]}, 1'h1);
			await(int_n_o, 1'h1, n);
			ck(n, 2560);
			{input_good_i, port_det_done_i, charge_done_i, ntc_above_float_i,
				input_limit_i, input_vreg_i, boost_fault_i, batt_ovp_i} <= 8'h00;
		end
		ck(host.int_count - c0 >= 8, 1'h1);
		discharge_mode_i <= 1'h1;
		discharge_over_limit_i <= 1'h1;
		await(discharge_switch_on_o, 1'h0, n);
		ck(n inside {[499:501]}, 1'h1);
		discharge_over_limit_i <= 1'h0;
		await(discharge_switch_on_o, 1'h1, n);
		ck(n inside {[18:21]}, 1'h1);
		@(posedge clk_i);
		discharge_fast_limit_i <= 1'h1;
		nx(2);
		ck(discharge_switch_on_o, 1'h0);
		{discharge_fast_limit_i, discharge_mode_i} <= 2'h0;
		await(discharge_switch_on_o, 1'h1, n);
		ck(n inside {[18:21]}, 1'h1);
		battery_switch_off_request_i <= 1'h1;
		nx(2);
		ck(battery_switch_on_o, 1'h0);
		battery_switch_off_request_i <= 1'h0;
		nx(2);
		ck(battery_switch_on_o, 1'h1);
		ship_delay_sel_i <= 1'h1;
		battery_switch_off_request_i <= 1'h1;
		await(battery_switch_on_o, 1'h0, n);
		ck(n inside {[29:32]}, 1'h1);
		battery_switch_off_request_i <= 1'h0;
		nx(2);
		ck(battery_switch_on_o, 1'h1);
		{ship_delay_sel_i, die_over_shutdown_i, die_reg_i} <= 3'h3;
		nx(2);
		ck({converter_enable_o, die_shutdown_flag_o}, 2'h1);
		{die_over_shutdown_i, die_below_recover_i} <= 2'h1;
		nx(2);
		ck({converter_enable_o, die_shutdown_flag_o}, 2'h2);
		{die_below_recover_i, die_reg_i, watchdog_enable_i} <= 3'h1;
		repeat (3) begin
			repeat (300) @(posedge clk_i);
			host.kick();
		end
		ck(watchdog_fault_o, 1'h0);
		await(watchdog_fault_o, 1'h1, n);
		ck(n inside {[385:410]}, 1'h1);
		ck(watchdog_defaults_o, 1'h1);
		host.kick();
		nx(2);
		ck(watchdog_fault_o, 1'h0);
		{watchdog_enable_i, batt_below_precharge_i, timer_enable_i} <= 3'h3;
		await(timer_fault_o, 1'h1, n);
		ck(n inside {[35980:36020]}, 1'h1);
		nx(2);
		ck(int_n_o, 1'h0);
		reference_enable_i <= 1'h0;
		nx(2);
		ck(timer_fault_o, 1'h0);
		finish_test;
	end
endmodule
